// [src/lpm_pkg.sv]
// constants, types and field layout of the power-mode sequencer
// Notes on behaviour
// - In either sleep mode any enabled interrupt source or a low reset pin ends sleep.
// - An interrupt wake from sleep starts exception handling and returns to active at the same speed.
// - Sleep is kept while the cpu interrupt mask is 1 or the requesting source is disabled.
// - Interrupt requests pass a two-flop synchroniser, adding at most two clock periods.
// - A low reset pin during sleep puts the cpu in reset and abandons sleep.
// - Medium-speed sleep runs at the rate picked by the two medium divider select bits.
// - Watch goes to subactive on timer a, f, g, external 0 or wake-pin requests while low-speed-on is 1.
// - Subsleep goes to subactive on timers a, c, f, g, async counter, serial, external 4..0 or wake pins.
// - No move to subactive while the cpu interrupt mask is 1 or the source is disabled.
// - Halt in subactive with standby select 1 and timer a select top 1 enters watch.
// - Halt in subactive with standby select 0, low-speed-on 1, timer a select top 1 enters subsleep.
// - Subactive ends on halt with timer a select top 1 and standby select or low-speed-on 1, or on a low reset pin, which resets as from standby.
// - In subactive the cpu runs at the subclock divided by 2, 4 or 8 per the sub divider bits.
package lpm_pkg;
  typedef enum logic [2:0] {
    active_high = 3'b000,
    active_medium = 3'b001,
    sleep_high = 3'b010,
    sleep_medium = 3'b011,
    watch = 3'b100,
    subsleep = 3'b101,
    subactive = 3'b110
  } mode_t;

  // register offsets
  localparam logic [3:0] system_control_one_addr = 4'h0;
  localparam logic [3:0] system_control_two_addr = 4'h1;
  localparam logic [3:0] timer_a_mode_reg_addr = 4'h2;
  localparam logic [3:0] enable_lo_addr = 4'h3;
  localparam logic [3:0] enable_mid_addr = 4'h4;
  localparam logic [3:0] enable_hi_addr = 4'h5;
  localparam logic [3:0] mode_status_addr = 4'h6;

  // field positions
  localparam int standby_select_bit = 7;
  localparam int low_speed_on_bit = 3;
  localparam int medium_divider_sel_hi_bit = 1;
  localparam int medium_divider_sel_lo_bit = 0;
  localparam int medium_speed_on_bit = 3;
  localparam int sub_divider_sel_hi_bit = 1;
  localparam int sub_divider_sel_lo_bit = 0;
  localparam int timer_a_clock_select_top_bit = 3;

  // reset values
  localparam logic [7:0] system_control_one_reset = 8'h00;
  localparam logic [7:0] system_control_two_reset = 8'h00;
  localparam logic [21:0] enable_reset = 22'h000000;

  // interrupt source lines: 0 timer a, 1 timer c, 2 timer f, 3 timer g,
  // 4 async counter, 9..5 external 4..0, 17..10 wake pins, 18..20 serial
  // a, b, c, 21 converter
  localparam int irq_width = 22;
  localparam logic [21:0] sleep_wake_mask = 22'h3FFFFF;
  localparam logic [21:0] watch_wake_mask = 22'h03FC2D;
  localparam logic [21:0] subsleep_wake_mask = 22'h1FFFFF;

  // divide ratios as log2
  localparam logic [2:0] medium_log2_sel0 = 3'h3;
  localparam logic [2:0] medium_log2_sel1 = 3'h4;
  localparam logic [2:0] medium_log2_sel2 = 3'h5;
  localparam logic [2:0] medium_log2_sel3 = 3'h6;
  localparam logic [2:0] sub_log2_div8 = 3'h3;
  localparam logic [2:0] sub_log2_div4 = 3'h2;
  localparam logic [2:0] sub_log2_div2 = 3'h1;
endpackage : lpm_pkg

// [src/rate_divider.sv]
// enable-pulse divider by a power of two
`timescale 1ns/1ps
module rate_divider (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // rate
  input wire logic tick_in,
  input wire logic [2:0] ratio_log2,
  output logic tick_out
);
  typedef struct packed {
    logic [5:0] count;
  } div_state_t;

  div_state_t state;
  div_state_t next_state;
  logic [5:0] mask;

  always_comb begin
    next_state = state;
    mask = 6'(({6'h00, 1'b1} << ratio_log2) - 7'h01);
    tick_out = tick_in && ((state.count & mask) == mask);
    if (tick_in) begin
      next_state.count = state.count + 6'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule : rate_divider

// [src/low_power_mode_controller.sv]
// power-mode sequencer with its control registers
`timescale 1ns/1ps
module low_power_mode_controller (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // cpu side
  input wire logic halt_exec,
  input wire logic cpu_int_mask,
  input wire logic chip_clear_pin_n,
  output logic cpu_reset,
  output logic exception_start,
  // interrupt sources
  input wire logic [21:0] irq_req,
  // subclock rate as one-cycle pulses
  input wire logic sub_tick,
  // mode and clock enables
  output logic [2:0] mode_state,
  output logic cpu_clk_en,
  output logic periph_clk_en
);
  typedef struct packed {
    lpm_pkg::mode_t mode;
    logic [7:0] system_control_one;
    logic [7:0] system_control_two;
    logic timer_a_clock_select_top;
    logic [21:0] enable;
    logic [21:0] sync_first;
    logic [21:0] sync_second;
    logic [7:0] rdata;
    logic exc;
    logic cpu_rst;
  } ctrl_state_t;

  ctrl_state_t state;
  ctrl_state_t next_state;
  logic [2:0] medium_log2;
  logic [2:0] sub_log2;
  logic medium_tick;
  logic sub_cpu_tick;
  logic standby_sel;
  logic low_speed_on;
  logic select_top;
  logic medium_speed_on;

  function automatic logic wake_hit(input logic [21:0] req,
                                    input logic [21:0] en,
                                    input logic [21:0] sel,
                                    input logic imask);
    wake_hit = !imask && |(req & en & sel);
  endfunction : wake_hit

  assign standby_sel = state.system_control_one[lpm_pkg::standby_select_bit];
  assign low_speed_on = state.system_control_one[lpm_pkg::low_speed_on_bit];
  assign select_top = state.timer_a_clock_select_top;
  assign medium_speed_on =
    state.system_control_two[lpm_pkg::medium_speed_on_bit];

  always_comb begin
    case ({state.system_control_one[lpm_pkg::medium_divider_sel_hi_bit],
           state.system_control_one[lpm_pkg::medium_divider_sel_lo_bit]})
      2'b00: medium_log2 = lpm_pkg::medium_log2_sel0;
      2'b01: medium_log2 = lpm_pkg::medium_log2_sel1;
      2'b10: medium_log2 = lpm_pkg::medium_log2_sel2;
      default: medium_log2 = lpm_pkg::medium_log2_sel3;
    endcase
  end

  always_comb begin
    case ({state.system_control_two[lpm_pkg::sub_divider_sel_hi_bit],
           state.system_control_two[lpm_pkg::sub_divider_sel_lo_bit]})
      2'b00: sub_log2 = lpm_pkg::sub_log2_div8;
      2'b01: sub_log2 = lpm_pkg::sub_log2_div4;
      default: sub_log2 = lpm_pkg::sub_log2_div2;
    endcase
  end

  rate_divider medium_div (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick_in(1'b1),
    .ratio_log2(medium_log2),
    .tick_out(medium_tick)
  );

  rate_divider sub_div (
    .sys_clk(sys_clk),
    .reset(reset),
    .tick_in(sub_tick),
    .ratio_log2(sub_log2),
    .tick_out(sub_cpu_tick)
  );

  always_comb begin
    next_state = state;
    next_state.exc = 1'b0;
    next_state.cpu_rst = 1'b0;
    next_state.sync_first = irq_req;
    next_state.sync_second = state.sync_first;
    // register writes
    if (reg_write) begin
      case (reg_addr)
        lpm_pkg::system_control_one_addr:
          next_state.system_control_one = reg_wdata;
        lpm_pkg::system_control_two_addr:
          next_state.system_control_two = reg_wdata;
        lpm_pkg::timer_a_mode_reg_addr:
          next_state.timer_a_clock_select_top =
            reg_wdata[lpm_pkg::timer_a_clock_select_top_bit];
        lpm_pkg::enable_lo_addr: next_state.enable[7:0] = reg_wdata;
        lpm_pkg::enable_mid_addr: next_state.enable[15:8] = reg_wdata;
        lpm_pkg::enable_hi_addr: next_state.enable[21:16] = reg_wdata[5:0];
        default: next_state.enable = state.enable;
      endcase
    end
    // register reads, answered next cycle
    next_state.rdata = 8'h00;
    if (reg_read) begin
      case (reg_addr)
        lpm_pkg::system_control_one_addr:
          next_state.rdata = state.system_control_one;
        lpm_pkg::system_control_two_addr:
          next_state.rdata = state.system_control_two;
        lpm_pkg::timer_a_mode_reg_addr:
          next_state.rdata[lpm_pkg::timer_a_clock_select_top_bit] = select_top;
        lpm_pkg::enable_lo_addr: next_state.rdata = state.enable[7:0];
        lpm_pkg::enable_mid_addr: next_state.rdata = state.enable[15:8];
        lpm_pkg::enable_hi_addr:
          next_state.rdata = {2'b00, state.enable[21:16]};
        lpm_pkg::mode_status_addr:
          next_state.rdata = {5'h00, state.mode};
        default: next_state.rdata = 8'h00;
      endcase
    end
    case (state.mode)
      lpm_pkg::active_high, lpm_pkg::active_medium: begin
        if (halt_exec) begin
          if (standby_sel && select_top) begin
            next_state.mode = lpm_pkg::watch;
          end else if (!standby_sel && !low_speed_on) begin
            next_state.mode = medium_speed_on ?
              lpm_pkg::sleep_medium : lpm_pkg::sleep_high;
          end
        end
      end
      lpm_pkg::sleep_high, lpm_pkg::sleep_medium: begin
        if (wake_hit(state.sync_second, state.enable,
                     lpm_pkg::sleep_wake_mask, cpu_int_mask)) begin
          next_state.mode = (state.mode == lpm_pkg::sleep_high) ?
            lpm_pkg::active_high : lpm_pkg::active_medium;
          next_state.exc = 1'b1;
        end
      end
      lpm_pkg::watch: begin
        if (low_speed_on &&
            wake_hit(state.sync_second, state.enable,
                     lpm_pkg::watch_wake_mask, cpu_int_mask)) begin
          next_state.mode = lpm_pkg::subactive;
          next_state.exc = 1'b1;
        end
      end
      lpm_pkg::subsleep: begin
        if (wake_hit(state.sync_second, state.enable,
                     lpm_pkg::subsleep_wake_mask, cpu_int_mask)) begin
          next_state.mode = lpm_pkg::subactive;
          next_state.exc = 1'b1;
        end
      end
      lpm_pkg::subactive: begin
        if (halt_exec && select_top) begin
          if (standby_sel) begin
            next_state.mode = lpm_pkg::watch;
          end else if (low_speed_on) begin
            next_state.mode = lpm_pkg::subsleep;
          end
        end
      end
      default: next_state.mode = lpm_pkg::active_high;
    endcase
    // reset pin clears mode and registers
    if (!chip_clear_pin_n) begin
      next_state.mode = lpm_pkg::active_high;
      next_state.system_control_one = lpm_pkg::system_control_one_reset;
      next_state.system_control_two = lpm_pkg::system_control_two_reset;
      next_state.timer_a_clock_select_top = 1'b0;
      next_state.enable = lpm_pkg::enable_reset;
      next_state.exc = 1'b0;
      next_state.cpu_rst = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= '0;
      state.mode <= lpm_pkg::active_high;
      state.system_control_one <= lpm_pkg::system_control_one_reset;
      state.system_control_two <= lpm_pkg::system_control_two_reset;
      state.enable <= lpm_pkg::enable_reset;
      state.cpu_rst <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    case (state.mode)
      lpm_pkg::active_high: begin
        cpu_clk_en = 1'b1;
        periph_clk_en = 1'b1;
      end
      lpm_pkg::active_medium: begin
        cpu_clk_en = medium_tick;
        periph_clk_en = 1'b1;
      end
      lpm_pkg::sleep_high: begin
        cpu_clk_en = 1'b0;
        periph_clk_en = 1'b1;
      end
      lpm_pkg::sleep_medium: begin
        cpu_clk_en = 1'b0;
        periph_clk_en = medium_tick;
      end
      lpm_pkg::subactive: begin
        cpu_clk_en = sub_cpu_tick;
        periph_clk_en = sub_tick;
      end
      lpm_pkg::watch, lpm_pkg::subsleep: begin
        cpu_clk_en = 1'b0;
        periph_clk_en = sub_tick;
      end
      default: begin
        cpu_clk_en = 1'b0;
        periph_clk_en = 1'b0;
      end
    endcase
  end

  assign reg_rdata = state.rdata;
  assign cpu_reset = state.cpu_rst;
  assign exception_start = state.exc;
  assign mode_state = state.mode;
endmodule : low_power_mode_controller

// [bench/lpm_partner.sv]
// cpu-side partner: subclock pulses and interrupt request lines
`timescale 1ns/1ps
module lpm_partner (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // request levels asked for by the bench
  input wire logic [21:0] fire,
  // toward the sequencer
  output logic [21:0] irq_req,
  output logic sub_tick
);
  // subclock at half rate; sources hold their request levels
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sub_tick <= 1'b0;
      irq_req <= 22'h000000;
    end else begin
      sub_tick <= !sub_tick;
      irq_req <= fire;
    end
  end
endmodule : lpm_partner

// [bench/lpm_properties.sv]
// assertion checker for the power-mode sequencer
`timescale 1ns/1ps
module lpm_properties (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register writes
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  // cpu side
  input wire logic halt_exec,
  input wire logic cpu_int_mask,
  input wire logic chip_clear_pin_n,
  input wire logic cpu_reset,
  input wire logic exception_start,
  input wire logic [21:0] irq_req,
  input wire logic [2:0] mode_state
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic standby_sel, low_speed_on, select_top;
  logic [21:0] en;
  // shadow of the mode control bits and enables
  always_ff @(posedge sys_clk) begin
    if (reset || !chip_clear_pin_n) begin
      {standby_sel, low_speed_on, select_top, en} <= '0;
    end else if (reg_write) begin
      case (reg_addr)
        4'h0: {standby_sel, low_speed_on} <= {reg_wdata[7], reg_wdata[3]};
        4'h2: select_top <= reg_wdata[3];
        4'h3: en[7:0] <= reg_wdata;
        4'h4: en[15:8] <= reg_wdata;
        4'h5: en[21:16] <= reg_wdata[5:0];
        default: ;
      endcase
    end
  end
  sequence s_sub_halt;
    mode_state == lpm_pkg::subactive && halt_exec && chip_clear_pin_n;
  endsequence
  sequence s_wake(logic [2:0] m, logic [21:0] k);
    (mode_state == m && !cpu_int_mask && chip_clear_pin_n &&
      |(irq_req & en & k)) [*3];
  endsequence
  a_halt_to_watch: assert property (
    s_sub_halt ##0 (standby_sel && select_top) |=>
      mode_state == lpm_pkg::watch)
    else $error("halt did not enter watch");
  a_halt_to_subsleep: assert property (
    s_sub_halt ##0 (!standby_sel && low_speed_on && select_top) |=>
      mode_state == lpm_pkg::subsleep)
    else $error("halt did not enter subsleep");
  a_halt_undefined_kept: assert property (
    s_sub_halt ##0 !select_top |=> mode_state == lpm_pkg::subactive)
    else $error("undefined halt changed mode");
  a_sleep_wake_irq: assert property (
    s_wake(lpm_pkg::sleep_high, lpm_pkg::sleep_wake_mask) |=>
      mode_state == lpm_pkg::active_high && exception_start)
    else $error("sleep wake missing or late");
  a_sleep_masked_kept: assert property (
    (mode_state == lpm_pkg::sleep_high && cpu_int_mask &&
      chip_clear_pin_n) [*3] |=> mode_state == lpm_pkg::sleep_high)
    else $error("masked sleep was left");
  a_watch_wake_sub: assert property (
    s_wake(lpm_pkg::watch, lpm_pkg::watch_wake_mask) ##0 low_speed_on |=>
      mode_state == lpm_pkg::subactive && exception_start)
    else $error("watch wake missing or late");
  a_subsleep_wake_sub: assert property (
    s_wake(lpm_pkg::subsleep, lpm_pkg::subsleep_wake_mask) |=>
      mode_state == lpm_pkg::subactive && exception_start)
    else $error("subsleep wake missing or late");
  a_sub_masked_kept: assert property (
    ((mode_state == lpm_pkg::watch || mode_state == lpm_pkg::subsleep) &&
      cpu_int_mask && chip_clear_pin_n) [*3] |=>
      mode_state != lpm_pkg::subactive)
    else $error("masked move to subactive");
  a_pin_low_reset: assert property (
    !chip_clear_pin_n ##1 !chip_clear_pin_n |=>
      mode_state == lpm_pkg::active_high && cpu_reset)
    else $error("reset pin did not reset");
endmodule : lpm_properties
bind low_power_mode_controller lpm_properties chk_u (.*);

// [bench/testbench.sv]
// self-checking bench for the power-mode sequencer
`timescale 1ns/1ps
module testbench;
  logic sys_clk, reset, reg_write, reg_read, halt_exec, cpu_int_mask;
  logic chip_clear_pin_n, cpu_reset, exception_start, sub_tick;
  logic cpu_clk_en, periph_clk_en;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [21:0] irq_req, fire;
  logic [2:0] mode_state;
  int errors, checks, n, p;
  low_power_mode_controller dut_u (.*);
  lpm_partner part_u (.*);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = !sys_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  task automatic put(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : put
  task automatic get(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 check(reg_rdata, e);
  endtask : get
  task automatic halt(input logic [2:0] e);
    @(posedge sys_clk);
    halt_exec <= 1'b1;
    @(posedge sys_clk);
    halt_exec <= 1'b0;
    #1 check(mode_state, e);
  endtask : halt
  // one source raised; the answer lands three edges after the line rises
  task automatic wake(input int b, input logic m, input logic [2:0] e,
                      input logic x);
    @(posedge sys_clk);
    fire <= 22'h000001 << b;
    cpu_int_mask <= m;
    repeat (4) @(posedge sys_clk);
    #1 check(mode_state, e);
    check(exception_start, x);
    @(posedge sys_clk);
    fire <= 22'h000000;
    repeat (4) @(posedge sys_clk);
  endtask : wake
  task automatic pin_low;
    @(posedge sys_clk);
    chip_clear_pin_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 check(mode_state, 3'h0);
    check(cpu_reset, 1'b1);
    @(posedge sys_clk);
    chip_clear_pin_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask : pin_low
  // whole divider periods in the window give exact pulse counts
  task automatic rate(input logic [3:0] a, input logic [7:0] sel,
                      input logic [7:0] e, input logic [7:0] f);
    put(a, sel);
    repeat (40) @(posedge sys_clk);
    n = 0;
    p = 0;
    repeat (128) begin
      @(negedge sys_clk);
      n += (cpu_clk_en === 1'b1);
      p += (periph_clk_en === 1'b1);
    end
    check(n[7:0], e);
    check(p[7:0], f);
  endtask : rate
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    conclude();
  end
  initial begin
    {reset, chip_clear_pin_n} = 2'b11;
    {reg_write, reg_read, halt_exec, cpu_int_mask} = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    fire = 22'h000000;
    errors = 0;
    checks = 0;
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    get(4'h0, 8'h00);
    get(4'h6, 8'h00);
    put(4'hF, 8'hFF);
    get(4'hF, 8'h00);
    put(4'h2, 8'hFF);
    get(4'h2, 8'h08);
    put(4'h3, 8'h01);
    halt(3'h2);
    wake(0, 1'b1, 3'h2, 1'b0);
    wake(1, 1'b0, 3'h2, 1'b0);
    wake(0, 1'b0, 3'h0, 1'b1);
    halt(3'h2);
    pin_low;
    get(4'h3, 8'h00);
    put(4'h1, 8'h08);
    put(4'h3, 8'h01);
    halt(3'h3);
    rate(4'h0, 8'h02, 8'h00, 8'h04);
    wake(0, 1'b0, 3'h1, 1'b1);
    rate(4'h0, 8'h03, 8'h02, 8'h80);
    put(4'h0, 8'h88);
    put(4'h2, 8'h08);
    put(4'h3, 8'h21);
    put(4'h5, 8'h04);
    halt(3'h4);
    wake(18, 1'b0, 3'h4, 1'b0);
    wake(0, 1'b0, 3'h6, 1'b1);
    rate(4'h1, 8'h00, 8'h08, 8'h40);
    rate(4'h1, 8'h01, 8'h10, 8'h40);
    rate(4'h1, 8'h02, 8'h20, 8'h40);
    put(4'h2, 8'h00);
    halt(3'h6);
    put(4'h2, 8'h08);
    put(4'h0, 8'h08);
    halt(3'h5);
    wake(18, 1'b1, 3'h5, 1'b0);
    wake(18, 1'b0, 3'h6, 1'b1);
    put(4'h0, 8'h88);
    halt(3'h4);
    wake(5, 1'b0, 3'h6, 1'b1);
    pin_low;
    conclude();
  end
endmodule : testbench
